// ### bench/asrb_host.sv
`timescale 1ns/1ps
// ==========================================
// Remote host station: single word transfers.
module asrb_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  // Released data shows the inverse, so stale data never looks valid.
  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'b00};
    htrans <= asrb_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? wd : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    rd = hrdata;
    hwdata <= ~hwdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [23:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, {8'h00, d}, r);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [23:0] d);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h00000000, r);
    d = r[23:0];
  endtask : rd

  task automatic load(input logic [3:0] code, input logic [23:0] v);
    wr(asrb_pkg::REG_STAGING_IDX, v);
    wr(asrb_pkg::REG_LOAD_CMD_IDX, {20'h00000, code});
  endtask : load
endmodule : asrb_host

// ### bench/axis_status_register_bank_bench.sv
`timescale 1ns/1ps
module axis_status_register_bank_bench;
  // Identity value is arbitrary.
  localparam logic [23:0] CHIP = 24'h3c3c07;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic all_stop_n = 1'b1;
  logic [3:0] in_pins = 4'h0;
  asrb_pkg::asrb_axis_t axis = '0;
  logic evt_start = 1'b0;
  logic evt_stop = 1'b0;
  logic coord_step = 1'b0;
  logic [23:0] coord_next = 24'h000000;
  asrb_pkg::asrb_params_t params;
  logic [23:0] logical_coordinate;
  logic [23:0] physical_coordinate;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;

  asrb_bank #(.CHIP_CODE(CHIP)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .all_stop_n(all_stop_n), .in_pins(in_pins), .axis(axis),
    .evt_start(evt_start), .evt_stop(evt_stop), .coord_step(coord_step),
    .coord_next(coord_next), .params(params),
    .logical_coordinate(logical_coordinate),
    .physical_coordinate(physical_coordinate), .irq(irq));
  asrb_host host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  always #25 hclk = ~hclk;

  // ==========================================
  // Comparison helpers.
  task automatic chk(input string nm, input logic [23:0] e,
    input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rc(input string nm, input logic [7:0] i,
    input logic [23:0] e);
    logic [23:0] d;
    host_u.rd(i, d);
    chk(nm, e, d);
  endtask : rc

  // The interrupt is combinational from registers; look mid-cycle.
  task automatic ci(input logic e);
    @(negedge hclk);
    chk("irq", {23'h000000, e}, {23'h000000, irq});
  endtask : ci

  // ==========================================
  // Scenarios.
  task automatic t_direct;
    logic [7:0] i;
    logic [23:0] v;
    for (int k = 0; k < 5; k++) begin
      i = asrb_pkg::REG_GOAL_IDX + 8'(k);
      v = 24'h81c35a + 24'(k);
      host_u.wr(i, v);
      rc("param", i, v);
    end
    chk("hresp", 24'h000000, {23'h000000, hresp});
    chk("goal out", 24'h81c35a, params.goal_coordinate);
    chk("ramp out", 24'h81c35e, params.ramp_rate);
    host_u.wr(asrb_pkg::REG_ORDER_IDX, 24'hffffff);
    host_u.wr(asrb_pkg::REG_SYNC_ORDER_IDX, 24'hffffff);
    rc("order", asrb_pkg::REG_ORDER_IDX, 24'h1f1f00);
    rc("sync order", asrb_pkg::REG_SYNC_ORDER_IDX, 24'h1f1f00);
  endtask : t_direct

  // Protected places are 0x01..0x03 and 0x0b..0x0f; 0x3c is unmapped.
  task automatic t_protect;
    for (int k = 1; k < 16; k++) begin
      if (k < 4 || k > 10) begin
        host_u.wr(8'(k), 24'h5a5a5a);
        rc("protected", 8'(k), 24'h000000);
      end
    end
    chk("prop two out", 24'h000000, params.property_set_two);
    host_u.wr(8'h3c, 24'hffffff);
    rc("unmapped", 8'h3c, 24'h000000);
    rc("chip code", asrb_pkg::REG_CHIP_IDX, CHIP);
  endtask : t_protect

  // Codes 1 and 2 land at 0x01/0x02, codes 3..7 at 0x0b..0x0f.
  task automatic t_load;
    logic [7:0] i;
    logic [23:0] v;
    for (int c = 1; c < 8; c++) begin
      i = (c < 3) ? 8'(c) : 8'(c + 8);
      v = (c == 1) ? asrb_pkg::COORD_MIN : 24'h0a0b00 + 24'(c);
      v = (c == 2) ? asrb_pkg::COORD_MAX : v;
      host_u.load(4'(c), v);
      rc("loaded", i, v);
    end
    chk("lpc out", asrb_pkg::COORD_MIN, logical_coordinate);
    chk("ppc out", asrb_pkg::COORD_MAX, physical_coordinate);
    chk("plus out", 24'h0a0b04, params.positive_soft_limit);
    @(posedge hclk);
    axis.phase <= asrb_pkg::ASRB_ACCEL;
    host_u.load(asrb_pkg::LD_LOGICAL, 24'h123456);
    host_u.load(asrb_pkg::LD_POS_LIM, 24'h123456);
    i = asrb_pkg::REG_LOGICAL_IDX;
    rc("moving lpc", i, asrb_pkg::COORD_MIN);
    rc("moving plus", asrb_pkg::REG_POS_LIM_IDX, 24'h0a0b04);
    @(posedge hclk);
    coord_step <= 1'b1;
    coord_next <= 24'h654321;
    @(posedge hclk);
    coord_step <= 1'b0;
    axis.phase <= asrb_pkg::ASRB_STOPPED;
    rc("moved lpc", asrb_pkg::REG_LOGICAL_IDX, 24'h654321);
  endtask : t_load

  task automatic t_events;
    @(posedge hclk);
    evt_start <= 1'b1;
    @(posedge hclk);
    evt_start <= 1'b0;
    rc("start event", asrb_pkg::REG_AXS_IDX, 24'h010000);
    @(posedge hclk);
    evt_stop <= 1'b1;
    @(posedge hclk);
    evt_stop <= 1'b0;
    host_u.wr(asrb_pkg::REG_AXS_IDX, 24'hffffff);
    rc("kept events", asrb_pkg::REG_AXS_IDX, 24'h030000);
    rc("irq status", asrb_pkg::REG_IRQ_STAT_IDX, 24'h000003);
    ci(1'b0);
    host_u.wr(asrb_pkg::REG_IRQ_EN_IDX, 24'h000001);
    ci(1'b1);
    host_u.wr(asrb_pkg::REG_IRQ_EN_IDX, 24'h000002);
    host_u.wr(asrb_pkg::REG_IRQ_CLR_IDX, 24'h000002);
    ci(1'b0);
    rc("irq cleared", asrb_pkg::REG_IRQ_STAT_IDX, 24'h000001);
    host_u.wr(asrb_pkg::REG_AXS_IDX, 24'h000000);
    rc("cleared", asrb_pkg::REG_AXS_IDX, 24'h000000);
  endtask : t_events

  // Pins pass a two-stage synchroniser, so allow four edges to settle.
  task automatic t_status;
    logic [23:0] e;
    @(posedge hclk);
    axis.dir_minus <= 1'b1;
    axis.sync_ready <= 1'b1;
    axis.rate <= asrb_pkg::RATE_MAX;
    axis.out_pins <= 4'ha;
    all_stop_n <= 1'b0;
    in_pins <= 4'h5;
    for (int p = 0; p < 4; p++) begin
      axis.phase <= asrb_pkg::asrb_phase_t'(p);
      repeat (4) @(posedge hclk);
      e = 24'h80c0a5 | (24'(p) << asrb_pkg::PHASE_LO);
      rc("status", 8'h00, e);
      rc("rate", 8'h03, (p == 0) ? 24'h0 : 24'h0030d4);
    end
    for (int b = 0; b < 5; b++) begin
      axis.limit_flags <= 5'(1 << b);
      repeat (4) @(posedge hclk);
      e = 24'he0e0a5 | (24'h000100 << b);
      rc("limit", asrb_pkg::REG_AXS_IDX, e);
      e = e | 24'h1f1f00;
      rc("order copy", asrb_pkg::REG_ORDER_IDX, e);
      rc("sync copy", asrb_pkg::REG_SYNC_ORDER_IDX, e);
    end
    rc("irq sources", asrb_pkg::REG_IRQ_STAT_IDX, 24'h00000d);
  endtask : t_status

  // ==========================================
  // Run control.
  task automatic conclude;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // The input monitor shows the synchroniser's reset level for two edges.
    repeat (2) @(posedge hclk);
    rc("reset status", asrb_pkg::REG_AXS_IDX, asrb_pkg::WORD_RESET);
    t_direct();
    t_protect();
    t_load();
    t_events();
    t_status();
    conclude();
  end

  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
endmodule : axis_status_register_bank_bench

// ### core/asrb_bank.sv
`timescale 1ns/1ps
// Functional notes
// - Goal, distance, speeds, ramp writable, used
// - Orders and status event directly writable
// - Trigger, limits, properties protected while moving
// - Coordinates change only on load/transition
// - Event bits 20:16, only clear writable
// - Direction bit 23, phase bits 22:21
// - All-stop bit 15 reads active-low pin
// - Sync-ready bit 14 while awaiting trigger
// - Bit 13 ORs limit flags 12:8
// - Limit flag bit mapping 12..8
// - Bits 7:4 outputs, 3:0 inputs
// - Order copies mirror status fields
// - Logical coordinate loads only when stopped
// - Physical coordinate loads only when stopped
// - Rate 14-bit, zero when stopped
// - Rate bits 23:14 read zero
// - Coordinates signed 24-bit two's complement
module asrb_bank #(
  parameter logic [23:0] CHIP_CODE = 24'h5a5a01
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic all_stop_n,
  input wire logic [3:0] in_pins,
  input wire asrb_pkg::asrb_axis_t axis,
  input wire logic evt_start,
  input wire logic evt_stop,
  input wire logic coord_step,
  input wire logic [23:0] coord_next,
  output asrb_pkg::asrb_params_t params,
  output logic [23:0] logical_coordinate,
  output logic [23:0] physical_coordinate,
  output logic irq
);

  default clocking chk_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // Pin synchronisers.
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 5'h1f;
      pin_s2 <= 5'h1f;
    end else begin
      pin_s1 <= {all_stop_n, in_pins};
      pin_s2 <= pin_s1;
    end
  end

  // ==========================================================
  // Bus address phase capture.
  logic wr_pend;
  logic [7:0] wr_idx;
  logic bus_take;
  assign bus_take = hsel && hready && htrans == asrb_pkg::HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      wr_pend <= bus_take && hwrite;
      if (bus_take) begin
        wr_idx <= haddr[9:2];
      end
    end
  end

  logic [23:0] wd;
  assign wd = hwdata[23:0];
  function automatic logic wr_to(input logic [7:0] idx);
    wr_to = wr_pend && wr_idx == idx;
  endfunction : wr_to

  logic moving;
  assign moving = axis.phase != asrb_pkg::ASRB_STOPPED;
  logic [23:0] write_staging;
  logic ld_go;
  logic [3:0] ld_code;
  logic ld_ok;

  // ==========================================================
  // Status word assembly.
  logic [4:0] motion_event_bits;
  logic any_limit_hit;
  logic [23:0] axis_status_word;
  logic [13:0] current_rate;
  assign any_limit_hit = |axis.limit_flags;
  // Speed is forced to zero whenever the phase says stopped.
  assign current_rate = moving ? axis.rate : 14'h0000;
  always_comb begin
    axis_status_word = asrb_pkg::WORD_RESET;
    axis_status_word[asrb_pkg::DIR_BIT] = axis.dir_minus;
    axis_status_word[asrb_pkg::PHASE_HI:asrb_pkg::PHASE_LO] =
      axis.phase;
    axis_status_word[asrb_pkg::EVT_HI:asrb_pkg::EVT_LO] =
      motion_event_bits;
    axis_status_word[asrb_pkg::ALL_STOP_BIT] = !pin_s2[4];
    axis_status_word[asrb_pkg::SYNC_RDY_BIT] = axis.sync_ready;
    axis_status_word[asrb_pkg::ANY_LIM_BIT] = any_limit_hit;
    axis_status_word[asrb_pkg::LIM_HI:asrb_pkg::LIM_LO] =
      axis.limit_flags;
    axis_status_word[asrb_pkg::OUT_HI:asrb_pkg::OUT_LO] =
      axis.out_pins;
    axis_status_word[asrb_pkg::IN_HI:asrb_pkg::IN_LO] =
      pin_s2[3:0];
  end

  // Fields that the order registers share with the status word.
  logic [23:0] mirror_mask;
  assign mirror_mask = 24'he0e0ff;

  // ==========================================================
  // Motion event bits: bit 0 start, bit 1 stop; set beats clear.
  logic evt_clr;
  assign evt_clr = wr_to(asrb_pkg::REG_AXS_IDX) &&
    wd[asrb_pkg::EVT_HI:asrb_pkg::EVT_LO] == asrb_pkg::EVT_CLEAR;
  logic [4:0] evt_set;
  assign evt_set = {3'b000, evt_stop, evt_start};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motion_event_bits <= 5'h00;
    end else begin
      // Nonzero writes are not a clear and leave the field alone.
      motion_event_bits <= (evt_clr ? 5'h00 : motion_event_bits)
        | evt_set;
    end
  end

  // ==========================================================
  // Parameter and order registers; the protected ones load only from staging.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      params.goal_coordinate <= asrb_pkg::WORD_RESET;
      params.travel_distance <= asrb_pkg::WORD_RESET;
      params.lower_speed <= asrb_pkg::WORD_RESET;
      params.upper_speed <= asrb_pkg::WORD_RESET;
      params.ramp_rate <= asrb_pkg::WORD_RESET;
      params.axis_order <= asrb_pkg::WORD_RESET;
      params.sync_order <= asrb_pkg::WORD_RESET;
      params.sync_trigger_setup <= asrb_pkg::WORD_RESET;
      params.positive_soft_limit <= asrb_pkg::WORD_RESET;
      params.negative_soft_limit <= asrb_pkg::WORD_RESET;
      params.property_set_one <= asrb_pkg::WORD_RESET;
      params.property_set_two <= asrb_pkg::WORD_RESET;
    end else begin
      if (wr_to(asrb_pkg::REG_GOAL_IDX)) begin
        params.goal_coordinate <= wd;
      end
      if (wr_to(asrb_pkg::REG_TRAVEL_IDX)) begin
        params.travel_distance <= wd;
      end
      if (wr_to(asrb_pkg::REG_LOWER_IDX)) begin
        params.lower_speed <= wd;
      end
      if (wr_to(asrb_pkg::REG_UPPER_IDX)) begin
        params.upper_speed <= wd;
      end
      if (wr_to(asrb_pkg::REG_RAMP_IDX)) begin
        params.ramp_rate <= wd;
      end
      if (wr_to(asrb_pkg::REG_ORDER_IDX)) begin
        params.axis_order <= wd & ~mirror_mask;
      end
      if (wr_to(asrb_pkg::REG_SYNC_ORDER_IDX)) begin
        params.sync_order <= wd & ~mirror_mask;
      end
      if (ld_ok) begin
        // Direct writes to these indices fall through unused.
        unique case (ld_code)
          asrb_pkg::LD_TRIG: params.sync_trigger_setup <= write_staging;
          asrb_pkg::LD_POS_LIM: params.positive_soft_limit <= write_staging;
          asrb_pkg::LD_NEG_LIM: params.negative_soft_limit <= write_staging;
          asrb_pkg::LD_PROP1: params.property_set_one <= write_staging;
          asrb_pkg::LD_PROP2: params.property_set_two <= write_staging;
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Staging register and load commands.
  assign ld_go = wr_to(asrb_pkg::REG_LOAD_CMD_IDX);
  assign ld_code = wd[3:0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_staging <= asrb_pkg::WORD_RESET;
    end else if (wr_to(asrb_pkg::REG_STAGING_IDX)) begin
      write_staging <= wd;
    end
  end

  // Loads while moving are dropped so the engine never sees a change.
  assign ld_ok = ld_go && !moving;

  // Coordinates: signed 24-bit values, loaded only when stopped.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      logical_coordinate <= asrb_pkg::WORD_RESET;
    end else if (ld_ok && ld_code == asrb_pkg::LD_LOGICAL) begin
      logical_coordinate <= write_staging;
    end else if (coord_step) begin
      logical_coordinate <= coord_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      physical_coordinate <= asrb_pkg::WORD_RESET;
    end else if (ld_ok && ld_code == asrb_pkg::LD_PHYSICAL) begin
      physical_coordinate <= write_staging;
    end
  end

  // ==========================================================
  // Interrupts.
  logic [3:0] irq_stat;
  logic [3:0] irq_en;
  logic [3:0] irq_src;
  logic sr_d;
  logic lim_d;
  assign irq_src = {any_limit_hit && !lim_d, axis.sync_ready && !sr_d,
    evt_stop, evt_start};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= 4'h0;
      irq_en <= 4'h0;
      sr_d <= 1'b0;
      lim_d <= 1'b0;
    end else begin
      sr_d <= axis.sync_ready;
      lim_d <= any_limit_hit;
      irq_stat <= (irq_stat & ~(wr_to(asrb_pkg::REG_IRQ_CLR_IDX) ?
        wd[3:0] : 4'h0)) | irq_src;
      if (wr_to(asrb_pkg::REG_IRQ_EN_IDX)) begin
        irq_en <= wd[3:0];
      end
    end
  end
  assign irq = |(irq_stat & irq_en);

  // ==========================================================
  // Read data, registered at the end of the address phase.
  logic [23:0] next_rd;
  always_comb begin
    unique case (haddr[9:2])
      asrb_pkg::REG_AXS_IDX: next_rd = axis_status_word;
      asrb_pkg::REG_LOGICAL_IDX: next_rd = logical_coordinate;
      asrb_pkg::REG_PHYSICAL_IDX: next_rd = physical_coordinate;
      asrb_pkg::REG_RATE_IDX: next_rd = {10'h000, current_rate};
      asrb_pkg::REG_ORDER_IDX:
        next_rd = (params.axis_order & ~mirror_mask) |
          (axis_status_word & mirror_mask);
      asrb_pkg::REG_GOAL_IDX: next_rd = params.goal_coordinate;
      asrb_pkg::REG_TRAVEL_IDX: next_rd = params.travel_distance;
      asrb_pkg::REG_LOWER_IDX: next_rd = params.lower_speed;
      asrb_pkg::REG_UPPER_IDX: next_rd = params.upper_speed;
      asrb_pkg::REG_RAMP_IDX: next_rd = params.ramp_rate;
      asrb_pkg::REG_SYNC_ORDER_IDX:
        next_rd = (params.sync_order & ~mirror_mask) |
          (axis_status_word & mirror_mask);
      asrb_pkg::REG_TRIG_IDX: next_rd = params.sync_trigger_setup;
      asrb_pkg::REG_POS_LIM_IDX: next_rd = params.positive_soft_limit;
      asrb_pkg::REG_NEG_LIM_IDX: next_rd = params.negative_soft_limit;
      asrb_pkg::REG_PROP1_IDX: next_rd = params.property_set_one;
      asrb_pkg::REG_PROP2_IDX: next_rd = params.property_set_two;
      asrb_pkg::REG_STAGING_IDX: next_rd = write_staging;
      asrb_pkg::REG_CHIP_IDX: next_rd = CHIP_CODE;
      asrb_pkg::REG_IRQ_STAT_IDX: next_rd = {20'h00000, irq_stat};
      asrb_pkg::REG_IRQ_EN_IDX: next_rd = {20'h00000, irq_en};
      default: next_rd = asrb_pkg::WORD_RESET;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (bus_take && !hwrite) begin
      hrdata <= {8'h00, next_rd};
    end
  end

  // ==========================================================
  // Checks.
  sequence s_load_stopped(logic [3:0] c);
    ld_go && !moving && ld_code == c;
  endsequence

  sequence s_read_of(logic [7:0] i);
    bus_take && !hwrite && haddr[9:2] == i;
  endsequence

  chk_logical_load: assert property (
    s_load_stopped(asrb_pkg::LD_LOGICAL) |=>
      logical_coordinate == $past(write_staging))
    else $error("logical coordinate load failed");
  chk_physical_load: assert property (
    s_load_stopped(asrb_pkg::LD_PHYSICAL) |=>
      physical_coordinate == $past(write_staging))
    else $error("physical coordinate load failed");
  chk_physical_hold: assert property (
    !(ld_ok && ld_code == asrb_pkg::LD_PHYSICAL) |=>
      $stable(physical_coordinate))
    else $error("physical coordinate changed unexpectedly");
  chk_logical_frozen: assert property (
    ld_go && moving && !coord_step |=> $stable(logical_coordinate))
    else $error("logical coordinate loaded while moving");
  chk_limit_frozen: assert property (
    moving |=> $stable(params.positive_soft_limit))
    else $error("soft limit changed while moving");
  chk_trig_load: assert property (
    s_load_stopped(asrb_pkg::LD_TRIG) |=>
      params.sync_trigger_setup == $past(write_staging))
    else $error("trigger setup load failed");
  chk_direct_ignored: assert property (
    wr_to(asrb_pkg::REG_PROP2_IDX) && !ld_go |=>
      $stable(params.property_set_two))
    else $error("protected register took direct write");
  chk_event_sticky: assert property (
    evt_start |=> motion_event_bits[0])
    else $error("start event lost");
  chk_event_clear: assert property (
    evt_clr && evt_set == 5'h00 |=>
      motion_event_bits == asrb_pkg::EVT_CLEAR)
    else $error("event field not cleared");
  chk_event_keep: assert property (
    wr_to(asrb_pkg::REG_AXS_IDX) && !evt_clr |=>
      motion_event_bits == ($past(motion_event_bits) | $past(evt_set)))
    else $error("event field changed by a nonzero write");
  chk_rate_stop: assert property (
    !moving |-> current_rate == 14'h0000)
    else $error("rate nonzero while stopped");
  chk_rate_reserved: assert property (
    s_read_of(asrb_pkg::REG_RATE_IDX) |=>
      hrdata[asrb_pkg::WORD_W-1:asrb_pkg::RATE_W] == 10'h000)
    else $error("rate reserved bits not zero");
  chk_all_stop: assert property (
    !all_stop_n [*3] |-> axis_status_word[asrb_pkg::ALL_STOP_BIT])
    else $error("all stop flag not shown");
  chk_all_stop_off: assert property (
    all_stop_n [*3] |-> !axis_status_word[asrb_pkg::ALL_STOP_BIT])
    else $error("all stop flag shown while pin idle");
  chk_any_limit: assert property (
    axis_status_word[asrb_pkg::ANY_LIM_BIT] ==
      (axis_status_word[asrb_pkg::LIM_HI:asrb_pkg::LIM_LO] != 5'h00))
    else $error("any limit flag mismatch");
  chk_order_mirror: assert property (
    s_read_of(asrb_pkg::REG_ORDER_IDX) |=>
      (hrdata[asrb_pkg::WORD_W-1:0] & mirror_mask) ==
        ($past(axis_status_word) & mirror_mask))
    else $error("order register mirror mismatch");
  chk_goal_write: assert property (
    wr_to(asrb_pkg::REG_GOAL_IDX) ##1 1'b1 |->
      params.goal_coordinate == $past(wd))
    else $error("goal write lost");

endmodule : asrb_bank

// ### core/asrb_pkg.sv
package asrb_pkg;

  // ==========================================================
  // Register indices; byte address is four times the index.
  localparam logic [7:0] REG_AXS_IDX = 8'h00;
  localparam logic [7:0] REG_LOGICAL_IDX = 8'h01;
  localparam logic [7:0] REG_PHYSICAL_IDX = 8'h02;
  localparam logic [7:0] REG_RATE_IDX = 8'h03;
  localparam logic [7:0] REG_ORDER_IDX = 8'h04;
  localparam logic [7:0] REG_GOAL_IDX = 8'h05;
  localparam logic [7:0] REG_TRAVEL_IDX = 8'h06;
  localparam logic [7:0] REG_LOWER_IDX = 8'h07;
  localparam logic [7:0] REG_UPPER_IDX = 8'h08;
  localparam logic [7:0] REG_RAMP_IDX = 8'h09;
  localparam logic [7:0] REG_SYNC_ORDER_IDX = 8'h0a;
  localparam logic [7:0] REG_TRIG_IDX = 8'h0b;
  localparam logic [7:0] REG_POS_LIM_IDX = 8'h0c;
  localparam logic [7:0] REG_NEG_LIM_IDX = 8'h0d;
  localparam logic [7:0] REG_PROP1_IDX = 8'h0e;
  localparam logic [7:0] REG_PROP2_IDX = 8'h0f;
  localparam logic [7:0] REG_STAGING_IDX = 8'h20;
  localparam logic [7:0] REG_CHIP_IDX = 8'h21;
  localparam logic [7:0] REG_IRQ_STAT_IDX = 8'h30;
  localparam logic [7:0] REG_IRQ_EN_IDX = 8'h31;
  localparam logic [7:0] REG_IRQ_CLR_IDX = 8'h32;
  localparam logic [7:0] REG_LOAD_CMD_IDX = 8'h33;

  // ==========================================================
  // Field layout of the axis status word.
  localparam int DIR_BIT = 23;
  localparam int PHASE_HI = 22;
  localparam int PHASE_LO = 21;
  localparam int EVT_HI = 20;
  localparam int EVT_LO = 16;
  localparam int ALL_STOP_BIT = 15;
  localparam int SYNC_RDY_BIT = 14;
  localparam int ANY_LIM_BIT = 13;
  localparam int LIM_HI = 12;
  localparam int LIM_LO = 8;
  localparam int OUT_HI = 7;
  localparam int OUT_LO = 4;
  localparam int IN_HI = 3;
  localparam int IN_LO = 0;
  localparam logic [4:0] EVT_CLEAR = 5'h00;
  localparam int RATE_W = 14;
  localparam int WORD_W = 24;
  localparam logic [23:0] WORD_RESET = 24'h000000;
  localparam logic [13:0] RATE_MAX = 14'h30d4;
  localparam logic [23:0] COORD_MIN = 24'h800000;
  localparam logic [23:0] COORD_MAX = 24'h7fffff;

  // Load command codes written to the load command register.
  localparam logic [3:0] LD_LOGICAL = 4'h1;
  localparam logic [3:0] LD_PHYSICAL = 4'h2;
  localparam logic [3:0] LD_TRIG = 4'h3;
  localparam logic [3:0] LD_POS_LIM = 4'h4;
  localparam logic [3:0] LD_NEG_LIM = 4'h5;
  localparam logic [3:0] LD_PROP1 = 4'h6;
  localparam logic [3:0] LD_PROP2 = 4'h7;

  // Interrupt sources: 0 start, 1 stop, 2 sync ready, 3 limit.
  localparam int IRQ_W = 4;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [1:0] {
    ASRB_STOPPED = 2'b00,
    ASRB_ACCEL = 2'b01,
    ASRB_FLAT = 2'b10,
    ASRB_DECEL = 2'b11
  } asrb_phase_t;

  // Live state of the axis as supplied by the motion engine.
  typedef struct packed {
    logic dir_minus;
    asrb_phase_t phase;
    logic sync_ready;
    logic [13:0] rate;
    logic [4:0] limit_flags;
    logic [3:0] out_pins;
  } asrb_axis_t;

  // Parameter set handed to the motion engine.
  typedef struct packed {
    logic [23:0] goal_coordinate;
    logic [23:0] travel_distance;
    logic [23:0] lower_speed;
    logic [23:0] upper_speed;
    logic [23:0] ramp_rate;
    logic [23:0] axis_order;
    logic [23:0] sync_order;
    logic [23:0] sync_trigger_setup;
    logic [23:0] positive_soft_limit;
    logic [23:0] negative_soft_limit;
    logic [23:0] property_set_one;
    logic [23:0] property_set_two;
  } asrb_params_t;

endpackage : asrb_pkg
